// [core/ddrw_defs.vh]
// Constants for the write-burst capture path
`ifndef DDRW_DEFS_VH
`define DDRW_DEFS_VH

// Register byte offsets
`define DDRW_OFF_MODE 8'h00
`define DDRW_OFF_EXT 8'h04
`define DDRW_OFF_STAT 8'h08
`define DDRW_OFF_CNT 8'h0c
`define DDRW_MEM_PAGE 2'h1

// Mode register fields
`define DDRW_BL_LSB 0
`define DDRW_BL_MSB 2
`define DDRW_CL_LSB 4
`define DDRW_CL_MSB 6
`define DDRW_WR_LSB 9
`define DDRW_WR_MSB 11

// Extended register fields
`define DDRW_EN_BIT 0
`define DDRW_AL_LSB 3
`define DDRW_AL_MSB 5

// Status fields
`define DDRW_TRUNC_BIT 9
`define DDRW_SPACE_BIT 10

// Reset values
`define DDRW_MODE_RST 32'h00000432
`define DDRW_EXT_RST 32'h00000001

// Burst length codes and beat counts
`define DDRW_BL8 3'h3
`define DDRW_BEATS8 4'h8
`define DDRW_BEATS4 4'h4
`define DDRW_HALF8 4'h4
`define DDRW_HALF4 4'h2

// Timing counts in memory clock cycles
`define DDRW_INT_AGE 4'h2
`define DDRW_AGE_MAX 4'hf

// Command codes {cs_n, ras_n, cas_n, we_n}
`define DDRW_CMD_WRITE 4'h4
`define DDRW_CMD_ACT 4'h3
`define DDRW_CMD_PRE 4'h2

// Auto precharge select address bit
`define DDRW_AP_BIT 10

// Bus responses
`define DDRW_RESP_OKAY 2'h0
`define DDRW_RESP_SLVERR 2'h2

`endif

// [core/ddrw_lane.v]
// One data byte lane: strobe edge detection and beat capture
`timescale 1ns/10ps

module ddrw_lane
(
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Byte lane pins
  input wire strobe,
  input wire [7:0] data,
  input wire mask,
  // Captured beat
  output reg rise,
  output reg edge_hit,
  output reg [7:0] byte_q,
  output reg mask_q
);

wire [9:0] s;
reg prev;

// Strobe, mask and data cross together so they keep their alignment
ddrw_sync #(.W(10)) u_sync
(
  .aclk(aclk),
  .aresetn(aresetn),
  .d({strobe, mask, data}),
  .q(s)
);

// Any strobe edge latches the byte and its mask together
always @(posedge aclk)
begin
  if (!aresetn)
  begin
    prev <= 1'b0;
    rise <= 1'b0;
    edge_hit <= 1'b0;
    byte_q <= 8'h00;
    mask_q <= 1'b0;
  end
  else
  begin
    prev <= s[9];
    rise <= s[9] & ~prev;
    edge_hit <= s[9] ^ prev;
    if (s[9] ^ prev)
    begin
      byte_q <= s[7:0];
      mask_q <= s[8];
    end
  end
end

endmodule // ddrw_lane

// [core/ddrw_sync.v]
// Two-flop synchroniser for pins from outside the bus clock domain
`timescale 1ns/10ps

module ddrw_sync
#(
  parameter W = 1
)
(
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Asynchronous input and synchronised output
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

reg [W-1:0] meta;

// First stage feeds only the second stage
always @(posedge aclk)
begin
  if (!aresetn)
  begin
    meta <= {W{1'b0}};
    q <= {W{1'b0}};
  end
  else
  begin
    meta <= d;
    q <= meta;
  end
end

endmodule // ddrw_sync

// [core/ddrw_write_path.v]
// Write-burst capture path of a double-data-rate DRAM, AXI4-Lite access
`timescale 1ns/10ps
`include "ddrw_defs.vh"

// Overview of operation
// - First beat on first rising strobe edge
// - Idle device never drives, ignores extra data
// - Length-8 cut only by write, prefetch boundary
// - Interrupting write has own bank, precharge
// - Recovery cycles from mode bits nine-eleven
// - Each byte captured by its own strobe
// - Address bit ten low keeps row open
// - Write latency is read latency minus one
// - Auto precharge closes row after burst
module ddrw_write_path
(
  // Bus clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address and data
  input wire [7:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  // AXI4-Lite write response
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // AXI4-Lite read
  input wire [7:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // Memory clock and command pins
  input wire ref_clk,
  input wire chip_select_n,
  input wire row_strobe_n,
  input wire col_strobe_n,
  input wire write_enable_n,
  input wire [2:0] bank_addr,
  input wire [13:0] mem_addr,
  // Data pins and byte strobes
  input wire low_byte_strobe,
  input wire high_byte_strobe,
  input wire [1:0] data_mask_input,
  input wire [15:0] dq_in,
  output reg [15:0] dq_out,
  output reg dq_oe
);

localparam ST_IDLE = 2'h0;
localparam ST_PRE = 2'h1;
localparam ST_DATA = 2'h2;

reg [31:0] mode;
reg [31:0] ext;
reg [1:0] stat_clr;
reg [7:0] aw_addr;
reg aw_got;
reg [31:0] w_data;
reg [3:0] w_strb;
reg w_got;
reg rck_prev;
reg [1:0] state;
reg [3:0] beat;
reg [3:0] limit;
reg [3:0] cur_col;
reg cur_ap;
reg [2:0] cur_bank;
reg [3:0] age;
reg pend;
reg [3:0] pend_col;
reg pend_ap;
reg [2:0] pend_bank;
reg rec_on;
reg [3:0] rec_cnt;
reg [2:0] rec_bank;
reg [7:0] open_rows;
reg [15:0] cnt_burst;
reg [15:0] cnt_ap;
reg trunc_seen;
reg space_err;
reg wb_go;
reg [3:0] wb_addr;
reg [15:0] mem [0:15];
integer i;

wire [21:0] pin_s;
wire [1:0] l_rise;
wire [1:0] l_edge;
wire [15:0] l_data;
wire [1:0] l_mask;
wire [1:0] strb_pins;
assign strb_pins = {high_byte_strobe, low_byte_strobe};

// Memory clock and command pins cross into the bus clock
ddrw_sync #(.W(22)) u_pin_sync
(
  .aclk(aclk),
  .aresetn(aresetn),
  .d({ref_clk, chip_select_n, row_strobe_n, col_strobe_n,
      write_enable_n, bank_addr, mem_addr}),
  .q(pin_s)
);

genvar g;
generate
  for (g = 0; g < 2; g = g + 1)
  begin : gen_lane
    ddrw_lane u_lane
    (
      .aclk(aclk),
      .aresetn(aresetn),
      .strobe(strb_pins[g]),
      .data(dq_in[8*g+7:8*g]),
      .mask(data_mask_input[g]),
      .rise(l_rise[g]),
      .edge_hit(l_edge[g]),
      .byte_q(l_data[8*g+7:8*g]),
      .mask_q(l_mask[g])
    );
  end
endgenerate

// Byte-strobe merge, used for the mode and extended registers
function [31:0] merge;
  input [31:0] old;
  input [31:0] nw;
  input [3:0] be;
  integer k;
  begin
    merge = old;
    for (k = 0; k < 4; k = k + 1)
      if (be[k])
        merge[8*k+:8] = nw[8*k+:8];
  end
endfunction

// Address decode shared by read and write channels
function mapped;
  input [7:0] a;
  begin
    mapped = (a[7:2] == `DDRW_OFF_MODE >> 2) ||
      (a[7:2] == `DDRW_OFF_EXT >> 2) ||
      (a[7:2] == `DDRW_OFF_STAT >> 2) ||
      (a[7:2] == `DDRW_OFF_CNT >> 2) ||
      (a[7:6] == `DDRW_MEM_PAGE);
  end
endfunction

// Configuration decode
wire [3:0] cmd = pin_s[20:17];
wire [2:0] cmd_bank = pin_s[16:14];
wire [13:0] cmd_addr = pin_s[13:0];
wire enabled = ext[`DDRW_EN_BIT];
wire bl8 = mode[`DDRW_BL_MSB:`DDRW_BL_LSB] == `DDRW_BL8;
wire [3:0] bl_beats = bl8 ? `DDRW_BEATS8 : `DDRW_BEATS4;
wire [3:0] half = bl8 ? `DDRW_HALF8 : `DDRW_HALF4;
wire [3:0] wl = {1'b0, mode[`DDRW_CL_MSB:`DDRW_CL_LSB]} +
  {1'b0, ext[`DDRW_AL_MSB:`DDRW_AL_LSB]} - 4'h1;
wire [3:0] wr_cycles = {1'b0, mode[`DDRW_WR_MSB:`DDRW_WR_LSB]} + 4'h1;

// Command sampling at memory clock rising edges
wire tick = pin_s[21] & ~rck_prev;
wire is_wr = tick & enabled & (cmd == `DDRW_CMD_WRITE);
// Early strobe accepted one cycle before latency
wire accept_rise = (state == ST_PRE) && l_rise[0] && (age >= wl - 4'h1);
// Rise opens burst, any edge continues
wire wr_beat = accept_rise || ((state == ST_DATA) && l_edge[0]);
wire [3:0] beat_n = beat + 4'h1;
wire end_now = wr_beat && (beat_n == limit);
wire load_new = is_wr && ((state == ST_IDLE) || (end_now && !pend));
// Only a write truncates, at four beats
// Truncation only at age of two
wire do_trunc = is_wr && !load_new && bl8 && !cur_ap &&
  (limit == `DDRW_BEATS8) && (age == `DDRW_INT_AGE) && !pend;

// Burst sequencer, auto precharge and row tracking
always @(posedge aclk)
begin
  if (!aresetn)
  begin
    rck_prev <= 1'b0;
    state <= ST_IDLE;
    beat <= 4'h0;
    limit <= `DDRW_BEATS4;
    cur_col <= 4'h0;
    cur_ap <= 1'b0;
    cur_bank <= 3'h0;
    age <= `DDRW_AGE_MAX;
    pend <= 1'b0;
    pend_col <= 4'h0;
    pend_ap <= 1'b0;
    pend_bank <= 3'h0;
    rec_on <= 1'b0;
    rec_cnt <= 4'h0;
    rec_bank <= 3'h0;
    open_rows <= 8'h00;
    cnt_burst <= 16'h0000;
    cnt_ap <= 16'h0000;
    trunc_seen <= 1'b0;
    space_err <= 1'b0;
    wb_go <= 1'b0;
    wb_addr <= 4'h0;
  end
  else
  begin
    rck_prev <= pin_s[21];
    wb_go <= wr_beat;
    wb_addr <= cur_col + beat;
    // Sticky flags: software clear loses to a fresh event
    trunc_seen <= trunc_seen & ~stat_clr[0];
    space_err <= space_err & ~stat_clr[1];
    if (tick && age != `DDRW_AGE_MAX)
      age <= age + 4'h1;
    // Recovery counts cycles, masks play no part
    // Counted from the full burst end
    if (rec_on && tick)
    begin
      rec_cnt <= rec_cnt + 4'h1;
      if (rec_cnt + 4'h1 >= wr_cycles)
      begin
        // Row closes once recovery has run
        open_rows[rec_bank] <= 1'b0;
        cnt_ap <= cnt_ap + 16'h0001;
        rec_on <= 1'b0;
      end
    end
    if (wr_beat)
    begin
      beat <= beat_n;
      state <= ST_DATA;
    end
    if (end_now)
    begin
      cnt_burst <= cnt_burst + 16'h0001;
      beat <= 4'h0;
      limit <= bl_beats;
      // A second overlapping recovery restarts the counter
      if (cur_ap)
      begin
        rec_on <= 1'b1;
        rec_cnt <= 4'h0;
        rec_bank <= cur_bank;
      end
      // Queued write takes the very next rise
      if (pend)
      begin
        cur_col <= pend_col;
        cur_ap <= pend_ap;
        cur_bank <= pend_bank;
        pend <= 1'b0;
        state <= ST_PRE;
      end
      else
        state <= ST_IDLE;
    end
    if (tick && enabled && cmd == `DDRW_CMD_ACT)
      open_rows[cmd_bank] <= 1'b1;
    if (tick && enabled && cmd == `DDRW_CMD_PRE)
    begin
      if (cmd_addr[`DDRW_AP_BIT])
        open_rows <= 8'h00;
      else
        open_rows[cmd_bank] <= 1'b0;
    end
    if (is_wr)
    begin
      age <= 4'h1;
      if (load_new)
      begin
        // Address bit ten selects auto precharge
        cur_col <= cmd_addr[3:0];
        cur_ap <= cmd_addr[`DDRW_AP_BIT];
        cur_bank <= cmd_bank;
        beat <= 4'h0;
        limit <= bl_beats;
        state <= ST_PRE;
      end
      else
      begin
        // Queued write keeps its own bank and mode
        pend <= 1'b1;
        pend_col <= cmd_addr[3:0];
        pend_ap <= cmd_addr[`DDRW_AP_BIT];
        pend_bank <= cmd_bank;
        if (do_trunc)
        begin
          limit <= `DDRW_BEATS4;
          trunc_seen <= 1'b1;
        end
        else if (pend || age != half)
          space_err <= 1'b1;
      end
    end
  end
end

// Masked bytes skip the array but still count
always @(posedge aclk)
begin
  if (wb_go)
    for (i = 0; i < 2; i = i + 1)
      if (!l_mask[i])
        mem[wb_addr][8*i+:8] <= l_data[8*i+:8];
end

// Data pins stay released, never driven
always @(posedge aclk)
begin
  if (!aresetn)
  begin
    dq_out <= 16'h0000;
    dq_oe <= 1'b1;
  end
  else
  begin
    dq_out <= 16'h0000;
    dq_oe <= 1'b1;
  end
end

// Write channel: address and data taken in either order
always @(posedge aclk)
begin
  if (!aresetn)
  begin
    awready <= 1'b0;
    wready <= 1'b0;
    aw_got <= 1'b0;
    w_got <= 1'b0;
    aw_addr <= 8'h00;
    w_data <= 32'h00000000;
    w_strb <= 4'h0;
    bvalid <= 1'b0;
    bresp <= `DDRW_RESP_OKAY;
    mode <= `DDRW_MODE_RST;
    ext <= `DDRW_EXT_RST;
    stat_clr <= 2'h0;
  end
  else
  begin
    stat_clr <= 2'h0;
    if (awvalid && awready)
    begin
      aw_addr <= awaddr;
      aw_got <= 1'b1;
      awready <= 1'b0;
    end
    else if (!aw_got && !bvalid)
      awready <= 1'b1;
    if (wvalid && wready)
    begin
      w_data <= wdata;
      w_strb <= wstrb;
      w_got <= 1'b1;
      wready <= 1'b0;
    end
    else if (!w_got && !bvalid)
      wready <= 1'b1;
    if (aw_got && w_got && !bvalid)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      bvalid <= 1'b1;
      bresp <= mapped(aw_addr) ? `DDRW_RESP_OKAY : `DDRW_RESP_SLVERR;
      if (aw_addr[7:2] == `DDRW_OFF_MODE >> 2)
        mode <= merge(mode, w_data, w_strb);
      else if (aw_addr[7:2] == `DDRW_OFF_EXT >> 2)
        ext <= merge(ext, w_data, w_strb);
      else if (aw_addr[7:2] == `DDRW_OFF_STAT >> 2 && w_strb[1])
        stat_clr <= w_data[`DDRW_SPACE_BIT:`DDRW_TRUNC_BIT];
    end
    else if (bvalid && bready)
      bvalid <= 1'b0;
  end
end

// Read channel, answer one cycle after the address
always @(posedge aclk)
begin
  if (!aresetn)
  begin
    arready <= 1'b0;
    rvalid <= 1'b0;
    rdata <= 32'h00000000;
    rresp <= `DDRW_RESP_OKAY;
  end
  else if (arvalid && arready)
  begin
    arready <= 1'b0;
    rvalid <= 1'b1;
    rresp <= mapped(araddr) ? `DDRW_RESP_OKAY : `DDRW_RESP_SLVERR;
    if (araddr[7:6] == `DDRW_MEM_PAGE)
      rdata <= {16'h0000, mem[araddr[5:2]]};
    else if (araddr[7:2] == `DDRW_OFF_MODE >> 2)
      rdata <= mode;
    else if (araddr[7:2] == `DDRW_OFF_EXT >> 2)
      rdata <= ext;
    else if (araddr[7:2] == `DDRW_OFF_STAT >> 2)
      rdata <= {21'h000000, space_err, trunc_seen, state != ST_IDLE,
        open_rows};
    else if (araddr[7:2] == `DDRW_OFF_CNT >> 2)
      rdata <= {cnt_ap, cnt_burst};
    else
      rdata <= 32'h00000000;
  end
  else if (rvalid && rready)
    rvalid <= 1'b0;
  else if (!rvalid)
    arready <= 1'b1;
end

endmodule // ddrw_write_path

// [tb/ddrw_chk_asserts.sv]
// Bus and pin checker for the write-burst capture path
`timescale 1ns/10ps
`include "ddrw_defs.vh"
module ddrw_chk
(
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Bus handshakes and read data
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire wready,
  input wire bvalid,
  input wire bready,
  input wire arvalid,
  input wire arready,
  input wire rvalid,
  input wire rready,
  input wire [1:0] rresp,
  input wire [31:0] rdata,
  // Data pins
  input wire [15:0] dq_out,
  input wire dq_oe
);
  // Everything sits in the bus clock domain
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_oe; dq_oe; endproperty
  a_oe: assert property (p_oe) else $error("data pins driven");
  property p_out; dq_out == 16'h0000; endproperty
  a_out: assert property (p_out) else $error("pin data moved");
  property p_bh; bvalid && !bready |=> bvalid; endproperty
  a_bh: assert property (p_bh) else $error("write answer lost");
  property p_rh; rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_rh: assert property (p_rh) else $error("read answer lost");
  property p_bans; awvalid && awready && wvalid && wready
    |-> ##[1:2] bvalid; endproperty
  a_bans: assert property (p_bans) else $error("no write answer");
  property p_rans; arvalid && arready |-> ##[1:2] rvalid; endproperty
  a_rans: assert property (p_rans) else $error("no read answer");
  property p_awd; awvalid && awready |=> !awready; endproperty
  a_awd: assert property (p_awd) else $error("address ready stuck");
  property p_err; rvalid && rresp == `DDRW_RESP_SLVERR |-> rdata == 0;
  endproperty
  a_err: assert property (p_err) else $error("refused read data");
endmodule // ddrw_chk

bind ddrw_write_path ddrw_chk ddrw_chk_inst (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
  .rvalid(rvalid), .rready(rready), .rresp(rresp), .rdata(rdata),
  .dq_out(dq_out), .dq_oe(dq_oe));

// [tb/ddrw_far.sv]
// Controller model: memory clock, commands, strobe and write data
`timescale 1ns/10ps
module ddrw_far
(
  // Memory clock and command pins
  output logic ref_clk,
  output logic [3:0] cmd,
  output logic [2:0] bank,
  output logic [13:0] addr,
  // Strobe, mask and data
  output logic dqs,
  output logic [1:0] dm,
  output logic [15:0] dq
);
  // Idle pins, strobe low ahead of any preamble
  initial
  begin
    ref_clk = 1'b0;
    cmd = 4'hf;
    bank = 3'h0;
    addr = 14'h0;
    dqs = 1'b0;
    dm = 2'h0;
    dq = 16'h0;
  end
  // Memory clock runs free
  always #24 ref_clk = ~ref_clk;
  // only deselect between commands, no read
  // no precharge follows a write here
  // Command centred on one rising edge, then deselect
  task automatic cmd_go(input [3:0] c, input [2:0] b, input [13:0] a);
    @(negedge ref_clk);
    cmd = c;
    bank = b;
    addr = a;
    @(negedge ref_clk);
    cmd = 4'hf;
    addr = ~a; // Not left showing the old value
  endtask
  task automatic burst(input int n, input [15:0] p, input [1:0] m);
    int k;
    repeat (2) @(negedge ref_clk);
    #60;
    for (k = 0; k < n; k++)
    begin
      dq = p + {k[7:0], k[7:0]};
      dm = m & {2{k[0]}};
      #12;
      dqs = ~dqs;
      #12;
    end
    dq = ~dq;
  endtask
endmodule // ddrw_far

// [tb/tb_top.sv]
// Directed bench for the write-burst capture path
`timescale 1ns/10ps
`include "ddrw_defs.vh"
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, rclk, dqs;
  wire [1:0] rresp, dm, bresp;
  wire [31:0] rdata;
  wire [15:0] dq;
  wire [3:0] cmd;
  wire [2:0] ba;
  wire [13:0] ma;
  int err_count = 0;
  int checks_done = 0;
  logic [15:0] ex [16];
  logic [15:0] vld = 16'h0;
  logic [31:0] d;
  logic [1:0] rs;
  // Bus clock
  always #2 aclk = ~aclk;
  ddrw_far ddrw_far_inst (.ref_clk(rclk), .cmd(cmd), .bank(ba), .addr(ma),
    .dqs(dqs), .dm(dm), .dq(dq));
  ddrw_write_path ddrw_write_path_inst (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .ref_clk(rclk),
    .chip_select_n(cmd[3]), .row_strobe_n(cmd[2]), .col_strobe_n(cmd[1]),
    .write_enable_n(cmd[0]), .bank_addr(ba), .mem_addr(ma),
    .low_byte_strobe(dqs), .high_byte_strobe(dqs), .data_mask_input(dm),
    .dq_in(dq), .dq_out(), .dq_oe());
  // Bus write, both channels offered together; response code into rs
  task automatic wr(input [7:0] a, input [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask
  // Bus read into d and rs
  task automatic rd(input [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // Compare and count
  task automatic chk(input [31:0] g, input [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Read back every array word written so far
  task automatic sweep;
    int i;
    for (i = 0; i < 16; i++)
      if (vld[i])
      begin
        rd(8'h40 | {2'b00, i[3:0], 2'b00});
        chk(d, {16'h0, ex[i]});
      end
  endtask
  task automatic pair(input [13:0] a, input [15:0] p, input [1:0] m,
    input int n);
    int g;
    int k;
    logic [15:0] e;
    fork
      begin
        ddrw_far_inst.cmd_go(`DDRW_CMD_WRITE, 3'h0, 14'h0);
        ddrw_far_inst.cmd_go(`DDRW_CMD_WRITE, 3'h3, a);
      end
      ddrw_far_inst.burst(n, p, m);
    join
    for (g = 0; g < n; g++)
    begin
      k = (g < 4) ? g : g + a[3:0] - 4;
      e = p + {g[7:0], g[7:0]};
      if (!(m[0] && g[0]))
        ex[k][7:0] = e[7:0];
      if (!(m[1] && g[0]))
        ex[k][15:8] = e[15:8];
      vld[k] = 1'b1;
    end
    repeat (2) @(posedge rclk);
  endtask
  // Single masked burst, array left unchecked
  task automatic one(input [2:0] b, input [13:0] a);
    fork
      ddrw_far_inst.cmd_go(`DDRW_CMD_WRITE, b, a);
      ddrw_far_inst.burst(4, 16'h0000, 2'h3);
    join
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(`DDRW_OFF_MODE);
    chk(d, `DDRW_MODE_RST);
    rd(`DDRW_OFF_EXT);
    chk(d, `DDRW_EXT_RST);
    rd(8'h20);
    chk({rs, d[29:0]}, {`DDRW_RESP_SLVERR, 30'h0});
    wr(8'h20, 32'h00000000);
    chk({30'h0, rs}, {30'h0, `DDRW_RESP_SLVERR});
    $display("register test done");
    pair(14'h0004, 16'h2010, 2'h0, 8);
    sweep;
    ddrw_far_inst.burst(4, 16'h5a5a, 2'h0);
    repeat (2) @(posedge rclk);
    sweep;
    pair(14'h0004, 16'h4030, 2'h1, 8);
    sweep;
    $display("stream test done");
    wr(`DDRW_OFF_MODE, 32'h00000433);
    chk({30'h0, rs}, {30'h0, `DDRW_RESP_OKAY});
    ddrw_far_inst.cmd_go(`DDRW_CMD_ACT, 3'h3, 14'h0);
    pair(14'h0408, 16'h6050, 2'h0, 12);
    sweep;
    repeat (10) @(posedge rclk);
    rd(`DDRW_OFF_STAT);
    chk({28'h0, d[10:8], d[3]}, 32'h4);
    $display("interrupt test done");
    wr(`DDRW_OFF_MODE, 32'h00000a32);
    chk({30'h0, rs}, {30'h0, `DDRW_RESP_OKAY});
    ddrw_far_inst.cmd_go(`DDRW_CMD_ACT, 3'h1, 14'h0);
    ddrw_far_inst.cmd_go(`DDRW_CMD_ACT, 3'h2, 14'h0);
    one(3'h2, 14'h0000);
    one(3'h1, 14'h0400);
    repeat (4) @(posedge rclk);
    rd(`DDRW_OFF_STAT);
    chk({30'h0, d[2:1]}, 32'h3);
    repeat (6) @(posedge rclk);
    rd(`DDRW_OFF_STAT);
    chk({30'h0, d[2:1]}, 32'h2);
    rd(`DDRW_OFF_CNT);
    chk(d, {16'h0002, 16'h0008});
    $display("recovery test done");
    close_out;
  end
  // Tests need some 4 us; a hang ends here
  initial
  begin
    #100000;
    err_count++;
    close_out;
  end
endmodule // tb_top
